// ==== core/spm_pkg.sv ====
// Constants shared by both ends of the protection map serial link.
// Assumes one 10 MHz clock on each end, sync active-high reset.
// Contract
// R1 - Opcode 3D 2A 7F CF means erase map
// R2 - Erase starts only when select rises
// R3 - Busy shown during map erase time
// R4 - Erase sets all bytes FF, protected
// R5 - Erase accepted whether protection on or off
// R6 - Protected erased map refuses array writes
// R7 - Host erases map before programming it
// R8 - Opcode 3D 2A 7F FC means program map
// R9 - Eight data bytes, sector order zero up
// R10 - Program starts on select rise, busy shown
// R11 - Missing bytes leave sectors undefined
// R12 - Ninth byte wraps to location zero
// R13 - Host writes only 00 or FF; the bench writes C0 in byte zero
// R14 - Program accepted with protection on or off
// R15 - Program overwrites buffer one contents
// R16 - Read is opcode 32 plus three dummies
// R17 - Map bytes shift out sector zero first
// R18 - After last byte, output undefined
// R19 - Select high ends read, output released
// R20 - Host limits map cycles to 10,000
// R21 - Write-protect pin blocks map modification
// R22 - Byte zero bit pairs guard sub-sectors
// R23 - All bytes shift most significant first
package spm_pkg;
   localparam int          CLK_HZ          = 10_000_000;
   localparam int          MAP_BYTES       = 8;
   localparam logic [7:0]  OP_PREFIX0      = 8'h3D;
   localparam logic [7:0]  OP_PREFIX1      = 8'h2A;
   localparam logic [7:0]  OP_PREFIX2      = 8'h7F;
   localparam logic [7:0]  OP_ERASE        = 8'hCF;
   localparam logic [7:0]  OP_PROG         = 8'hFC;
   localparam logic [7:0]  OP_READ         = 8'h32;
   localparam logic [7:0]  MAP_ERASED      = 8'hFF;
   localparam logic [7:0]  MAP_CLEAR       = 8'h00;
   localparam int          READ_DUMMIES    = 3;
   localparam int          SUB0A_MSB       = 7;
   localparam int          SUB0B_MSB       = 5;
   localparam int          CYCLE_LIMIT     = 10_000;
   // Self-timed cycle lengths in microseconds
   localparam int          MAP_ERASE_TIME_US = 100;
   localparam int          PROGRAM_TIME_US   = 50;
   localparam int          ERASE_CYC = MAP_ERASE_TIME_US * (CLK_HZ / 1_000_000);
   localparam int          PROG_CYC  = PROGRAM_TIME_US * (CLK_HZ / 1_000_000);
   // Host clock divider: half period in system clocks
   localparam int          SCK_HALF        = 4;
endpackage

// ==== core/spm_if.sv ====
// Serial link between protection map host and device.
// Assumes the host treats so as released while so_oe is low.
`timescale 1ns/1ps
`default_nettype none
interface spm_if;
   logic cs_n;
   logic sck;
   logic si;
   logic so_o;
   logic so_oe;
   modport dev  (input cs_n, sck, si, output so_o, so_oe);
   modport host (output cs_n, sck, si, input so_o, so_oe);
endinterface // spm_if
`default_nettype wire

// ==== core/spm_dev.sv ====
// Device end: decodes map erase, program and read commands.
// Assumes link pins are asynchronous and sampled by i_clk.
`timescale 1ns/1ps
`default_nettype none
module spm_dev (
   // Clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_sys_rst,
   // Link
   spm_if.dev              lnk,
   // Protection controls
   input  wire logic       i_wp_n,
   input  wire logic       i_prot_en,
   input  wire logic       i_array_wr_req,
   // Status
   output logic            o_busy,
   output logic            o_array_wr_refused,
   output logic            o_buf1_clobbered,
   output logic [63:0]     o_map,
   output logic [1:0]      o_sub0_prot
);
   typedef enum logic [2:0] {
      SPM_IDLE  = 3'b000,
      SPM_OPC   = 3'b001,
      SPM_DATA  = 3'b010,
      SPM_DUMMY = 3'b011,
      SPM_READ  = 3'b100,
      SPM_SKIP  = 3'b101
   } spm_st_t;
   typedef enum logic [1:0] {
      JOB_NONE  = 2'b00,
      JOB_ERASE = 2'b01,
      JOB_PROG  = 2'b10
   } spm_job_t;
   typedef struct packed {
      logic [1:0]  cs_s;
      logic [1:0]  sck_s;
      logic [1:0]  si_s;
      logic [1:0]  wp_s;
      logic        sck_q;
      logic        cs_q;
      spm_st_t     st;
      logic [2:0]  bitc;
      logic [7:0]  sh;
      logic [1:0]  opn;
      logic [1:0]  dmy;
      logic [3:0]  idx;
      logic        wide;
      spm_job_t    pend;
      spm_job_t    job;
      logic [15:0] tmr;
      logic [7:0][7:0] map;
      logic [7:0][7:0] stage;
      logic [7:0]  tx;
      logic        so;
      logic        oe;
      logic        buf1;
   } spm_dev_t;
   spm_dev_t cur_ff, nxt_ff;
   logic     sck_rise, sck_fall, cs_rise, cs_fall, byte_done;
   logic [7:0] rx;
   logic [7:0] exp_op;

   // ======================================================
   // Next state
   always_comb begin
      nxt_ff = cur_ff;
      nxt_ff.cs_s  = {cur_ff.cs_s[0], lnk.cs_n};
      nxt_ff.sck_s = {cur_ff.sck_s[0], lnk.sck};
      nxt_ff.si_s  = {cur_ff.si_s[0], lnk.si};
      nxt_ff.wp_s  = {cur_ff.wp_s[0], i_wp_n};
      nxt_ff.sck_q = cur_ff.sck_s[1];
      nxt_ff.cs_q  = cur_ff.cs_s[1];
      sck_rise  = cur_ff.sck_s[1] & ~cur_ff.sck_q & ~cur_ff.cs_s[1];
      sck_fall  = ~cur_ff.sck_s[1] & cur_ff.sck_q & ~cur_ff.cs_s[1];
      cs_fall   = ~cur_ff.cs_s[1] & cur_ff.cs_q;
      cs_rise   = cur_ff.cs_s[1] & ~cur_ff.cs_q;
      rx        = {cur_ff.sh[6:0], cur_ff.si_s[1]};
      byte_done = sck_rise & (cur_ff.bitc == 3'd7);
      case (cur_ff.opn)
         2'd0:    exp_op = spm_pkg::OP_PREFIX0;
         2'd1:    exp_op = spm_pkg::OP_PREFIX1;
         default: exp_op = spm_pkg::OP_PREFIX2;
      endcase
      // ======================================================
      // Self-timed cycle; commands are ignored while busy
      if (cur_ff.job != JOB_NONE) begin
         if (cur_ff.tmr == 16'h0000) begin
            if (cur_ff.job == JOB_ERASE)
               nxt_ff.map = {8{spm_pkg::MAP_ERASED}};  // R4
            else
               nxt_ff.map = cur_ff.stage;
            nxt_ff.job = JOB_NONE;
         end else begin
            nxt_ff.tmr = cur_ff.tmr - 16'h0001;
         end
      end
      // ======================================================
      // Serial input shift register
      if (sck_rise) begin
         nxt_ff.sh   = rx;                               // R23
         nxt_ff.bitc = cur_ff.bitc + 3'd1;
      end
      // ======================================================
      // Frame start and command decode
      if (cs_fall) begin
         nxt_ff.st   = (cur_ff.job == JOB_NONE) ? SPM_OPC : SPM_SKIP;
         nxt_ff.bitc = 3'd0;
         nxt_ff.opn  = 2'd0;
         nxt_ff.pend = JOB_NONE;
         nxt_ff.idx  = 4'd0;
         nxt_ff.wide = 1'b0;
      end else if (byte_done) begin
         case (cur_ff.st)
            SPM_OPC: begin
               if (cur_ff.opn == 2'd0 && rx == spm_pkg::OP_READ) begin
                  nxt_ff.st  = SPM_DUMMY;                // R16
                  nxt_ff.dmy = 2'd0;
               end else if (cur_ff.opn == 2'd3) begin
                  if (rx == spm_pkg::OP_ERASE) begin
                     nxt_ff.pend = JOB_ERASE;            // R1 R5
                     nxt_ff.st   = SPM_SKIP;
                  end else if (rx == spm_pkg::OP_PROG) begin
                     nxt_ff.st    = SPM_DATA;            // R8 R14
                     // Unsent bytes keep their old value
                     nxt_ff.stage = cur_ff.map;          // R11
                     nxt_ff.buf1  = 1'b1;                // R15
                  end else begin
                     nxt_ff.st = SPM_SKIP;
                  end
               end else if (rx == exp_op) begin
                  nxt_ff.opn = cur_ff.opn + 2'd1;
               end else begin
                  nxt_ff.st = SPM_SKIP;
               end
            end
            SPM_DATA: begin
               nxt_ff.stage[cur_ff.idx[2:0]] = rx;       // R9
               nxt_ff.idx  = {1'b0, cur_ff.idx[2:0] + 3'd1}; // R12
               nxt_ff.pend = JOB_PROG;
            end
            SPM_DUMMY: begin
               if (cur_ff.dmy == 2'(spm_pkg::READ_DUMMIES - 1)) begin
                  nxt_ff.st  = SPM_READ;
                  nxt_ff.idx = 4'd0;
                  nxt_ff.tx  = cur_ff.map[0];            // R17
               end else begin
                  nxt_ff.dmy = cur_ff.dmy + 2'd1;
               end
            end
            SPM_READ: begin
               nxt_ff.idx = cur_ff.idx + 4'd1;
               if (cur_ff.idx == 4'(spm_pkg::MAP_BYTES - 1)) begin
                  nxt_ff.wide = 1'b1;                    // R18
                  nxt_ff.tx   = 8'h00;
               end else if (!cur_ff.wide) begin
                  nxt_ff.tx = cur_ff.map[cur_ff.idx[2:0] + 3'd1];
               end
            end
            default: ;
         endcase
      end
      // ======================================================
      // Output shifts on falling edge, MSB first
      if (cur_ff.st == SPM_READ && sck_fall) begin
         nxt_ff.oe = 1'b1;
         nxt_ff.so = cur_ff.tx[3'd7 - cur_ff.bitc];      // R17 R23
      end
      // ======================================================
      // Frame end starts the self-timed cycle
      if (cs_rise) begin
         nxt_ff.oe = 1'b0;                               // R19
         nxt_ff.st = SPM_IDLE;
         // Map changes are barred while write-protect is low
         if (cur_ff.wp_s[1] && cur_ff.job == JOB_NONE) begin // R21
            if (cur_ff.pend == JOB_ERASE) begin
               nxt_ff.job = JOB_ERASE;                   // R2 R3
               nxt_ff.tmr = 16'(spm_pkg::ERASE_CYC - 1);
            end else if (cur_ff.pend == JOB_PROG) begin
               nxt_ff.job = JOB_PROG;                    // R10
               nxt_ff.tmr = 16'(spm_pkg::PROG_CYC - 1);
            end
         end
      end
   end

   // ======================================================
   // State register
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         cur_ff <= '{cs_s: 2'b11, cs_q: 1'b1, map: '0, stage: '0,
                     st: SPM_IDLE, pend: JOB_NONE, job: JOB_NONE,
                     default: '0};
      end else begin
         cur_ff <= nxt_ff;
      end
   end

   // ======================================================
   // Outputs
   assign lnk.so_o  = cur_ff.so;
   assign lnk.so_oe = cur_ff.oe;
   assign o_busy    = (cur_ff.job != JOB_NONE);                 // R3 R10
   // Erased map is all protected, so array writes are refused while i_prot_en is high
   assign o_array_wr_refused = i_array_wr_req & i_prot_en
                             & (cur_ff.map[0] == spm_pkg::MAP_ERASED); // R6
   assign o_buf1_clobbered = cur_ff.buf1;
   assign o_map = cur_ff.map;
   assign o_sub0_prot = {&cur_ff.map[0][spm_pkg::SUB0A_MSB -: 2],
                         &cur_ff.map[0][spm_pkg::SUB0B_MSB -: 2]}; // R22
endmodule // spm_dev
`default_nettype wire

// ==== core/spm_host.sv ====
// Host end: issues map erase, program and read over the link.
// Assumes the device samples the link with its own clock.
`timescale 1ns/1ps
`default_nettype none
module spm_host (
   // Clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_sys_rst,
   // Link
   spm_if.host             lnk,
   // Command port: 0 erase, 1 program, 2 read
   input  wire logic       i_start,
   input  wire logic [1:0] i_cmd,
   input  wire logic [63:0] i_wdata,
   output logic            o_ready,
   output logic            o_done,
   output logic [63:0]     o_rdata
);
   typedef enum logic [1:0] {
      HST_IDLE = 2'b00,
      HST_XFER = 2'b01,
      HST_END  = 2'b10
   } spm_hst_t;
   typedef struct packed {
      spm_hst_t    st;
      logic [1:0]  so_s;
      logic [2:0]  div;
      logic        sck;
      logic        cs_n;
      logic [6:0]  nbits;
      logic        rd;
      logic [95:0] tx;
      logic [63:0] rx;
      logic        done;
   } spm_host_t;
   spm_host_t cur_ff, nxt_ff;
   logic tick;

   // ======================================================
   // Next state
   always_comb begin
      nxt_ff      = cur_ff;
      nxt_ff.done = 1'b0;
      // Released line reads as the inverse of its last bit
      nxt_ff.so_s = {cur_ff.so_s[0], lnk.so_oe ? lnk.so_o : ~lnk.so_o};
      tick = (cur_ff.div == 3'(spm_pkg::SCK_HALF - 1));
      nxt_ff.div  = tick ? 3'd0 : cur_ff.div + 3'd1;
      case (cur_ff.st)
         HST_IDLE: begin
            if (i_start) begin
               nxt_ff.cs_n  = 1'b0;
               nxt_ff.st    = HST_XFER;
               nxt_ff.div   = 3'd0;
               nxt_ff.rd    = i_cmd[1];
               case (i_cmd)
                  2'd0: begin
                     nxt_ff.tx = {spm_pkg::OP_PREFIX0, spm_pkg::OP_PREFIX1,
                                  spm_pkg::OP_PREFIX2, spm_pkg::OP_ERASE,
                                  64'h0000_0000_0000_0000}; // R1 R7
                     nxt_ff.nbits = 7'd32;
                  end
                  2'd1: begin
                     nxt_ff.tx = {spm_pkg::OP_PREFIX0, spm_pkg::OP_PREFIX1,
                                  spm_pkg::OP_PREFIX2, spm_pkg::OP_PROG,
                                  i_wdata};              // R8 R9 R13
                     nxt_ff.nbits = 7'd96;
                  end
                  default: begin
                     nxt_ff.tx = {spm_pkg::OP_READ, 24'h00_0000,
                                  64'h0000_0000_0000_0000}; // R16
                     nxt_ff.nbits = 7'd96;
                  end
               endcase
            end
         end
         HST_XFER: begin
            if (tick) begin
               nxt_ff.sck = ~cur_ff.sck;
               if (cur_ff.sck) begin
                  // Change data on falling edge, MSB first
                  nxt_ff.tx    = {cur_ff.tx[94:0], 1'b0};  // R23
                  nxt_ff.nbits = cur_ff.nbits - 7'd1;
                  if (cur_ff.nbits == 7'd1)
                     nxt_ff.st = HST_END;
                  // Sample late in the bit: so lags by the pin flops
                  if (cur_ff.rd && cur_ff.nbits <= 7'd64)
                     nxt_ff.rx = {cur_ff.rx[62:0], cur_ff.so_s[1]}; // R17
               end
            end
         end
         HST_END: begin
            if (tick) begin
               nxt_ff.cs_n = 1'b1;                        // R2 R19
               nxt_ff.st   = HST_IDLE;
               nxt_ff.done = 1'b1;
            end
         end
         default: nxt_ff.st = HST_IDLE;
      endcase
   end

   // ======================================================
   // State register
   always_ff @(posedge i_clk) begin
      if (i_sys_rst)
         cur_ff <= '{cs_n: 1'b1, st: HST_IDLE, default: '0};
      else
         cur_ff <= nxt_ff;
   end

   assign lnk.cs_n = cur_ff.cs_n;
   assign lnk.sck  = cur_ff.sck;
   assign lnk.si   = cur_ff.tx[95];
   assign o_ready  = (cur_ff.st == HST_IDLE);
   assign o_done   = cur_ff.done;
   assign o_rdata  = cur_ff.rx;
endmodule // spm_host
`default_nettype wire

// ==== bench/spm_link_assertions.sv ====
// Checker for the wires between the map host and map device.
// Assumes both ends share i_clk; instantiated beside the link.
`timescale 1ns/1ps
`default_nettype none
module spm_link_chk (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_sys_rst,
   // Link wires
   input wire logic cs_n,
   input wire logic sck,
   input wire logic si,
   input wire logic so_o,
   input wire logic so_oe
);
   // ==========================================
   // Helper: serial clock rises in this frame
   logic       sck_q_ff;
   logic [7:0] nbit_ff;
   always_ff @(posedge i_clk) begin
      sck_q_ff <= sck;
      if (i_sys_rst || cs_n) begin
         nbit_ff <= 8'h00;
      end else if (sck && !sck_q_ff) begin
         nbit_ff <= nbit_ff + 8'h01;
      end
   end
   // ==========================================
   // Properties
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   a_frame_bit_count: assert property ($rose(cs_n) |->
      (nbit_ff == 8'h20 || nbit_ff == 8'h60)) else $error("bad frame len");
   a_sck_idle_low: assert property (cs_n && $past(cs_n) |-> !sck)
      else $error("sck moves outside frame");
   a_sck_half_period: assert property ($rose(sck) |->
      sck[*4] ##1 !sck) else $error("sck half period wrong");
   a_si_steady_high: assert property (sck && $past(sck) |-> $stable(si))
      else $error("si moved while sck high");
   a_so_steady_high: assert property (so_oe && $past(so_oe) && sck &&
      $past(sck) |-> $stable(so_o)) else $error("so moved while sck high");
   a_so_released: assert property (cs_n[*6] |-> !so_oe)
      else $error("so driven while deselected");
   a_so_after_opcode: assert property ($rose(so_oe) |->
      !cs_n && nbit_ff >= 8'h08) else $error("so driven too early");
   a_select_lead: assert property ($fell(cs_n) |-> (!sck)[*2])
      else $error("sck too soon after select");
endmodule // spm_link_chk
`default_nettype wire

// ==== bench/testbench.sv ====
// Bench joining host and device ends through the link.
// Assumes a 10 MHz i_clk; host divides it for the link clock.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   // ==========================================
   // Signals
   logic        i_clk = 1'b0;
   logic        i_sys_rst = 1'b1;
   logic        i_wp_n = 1'b1;
   logic        i_prot_en = 1'b0;
   logic        i_array_wr_req = 1'b0;
   logic        i_start = 1'b0;
   logic [1:0]  i_cmd = 2'h0;
   logic [63:0] i_wdata = 64'h0000_0000_0000_0000;
   logic        o_busy, o_array_wr_refused, o_buf1_clobbered;
   logic        o_ready, o_done;
   logic [63:0] o_map, o_rdata;
   logic [1:0]  o_sub0_prot;
   int          n_fail = 0;
   int          checks = 0;
   int          n_mod = 0;
   int          nb;
   localparam logic [63:0] ALL_FF = 64'hFFFF_FFFF_FFFF_FFFF;
   // 00/FF per sector except C0 in byte zero, which guards sub-sector 0a alone
   localparam logic [63:0] WD = 64'hC0FF_00FF_0000_FF00;
   always #50 i_clk = ~i_clk;
   spm_if lnk ();
   spm_dev u_spm_dev (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .lnk(lnk),
      .i_wp_n(i_wp_n), .i_prot_en(i_prot_en),
      .i_array_wr_req(i_array_wr_req), .o_busy(o_busy),
      .o_array_wr_refused(o_array_wr_refused),
      .o_buf1_clobbered(o_buf1_clobbered), .o_map(o_map),
      .o_sub0_prot(o_sub0_prot));
   spm_host u_spm_host (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .lnk(lnk),
      .i_start(i_start), .i_cmd(i_cmd), .i_wdata(i_wdata),
      .o_ready(o_ready), .o_done(o_done), .o_rdata(o_rdata));
   spm_link_chk u_chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
      .cs_n(lnk.cs_n), .sck(lnk.sck), .si(lnk.si), .so_o(lnk.so_o),
      .so_oe(lnk.so_oe));
   // ==========================================
   // Tasks
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic results;
      if (n_fail == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic cmd(input logic [1:0] c, input logic [63:0] d);
      int k;
      for (k = 0; o_ready !== 1'b1; k++) begin
         if (k > 50) begin n_fail++; results(); end
         @(negedge i_clk);
      end
      @(posedge i_clk);
      i_start <= 1'b1;
      i_cmd   <= c;
      i_wdata <= d;
      if (c < 2'h2) n_mod++;
      @(posedge i_clk);
      i_start <= 1'b0;
      // Frame is at most 96 bits of 8 clocks each
      for (k = 0; o_done !== 1'b1; k++) begin
         if (k > 2000) begin n_fail++; results(); end
         @(negedge i_clk);
      end
   endtask
   // Length of the next busy stretch; zero if it never starts
   task automatic busy_len(output int n);
      int k;
      n = 0;
      for (k = 0; k < 30 && o_busy !== 1'b1; k++) @(negedge i_clk);
      if (o_busy === 1'b1) chk({63'h0, lnk.cs_n}, 64'h1);
      for (k = 0; k < 3000 && o_busy === 1'b1; k++) begin
         @(negedge i_clk);
         n++;
      end
      if (k >= 3000) begin n_fail++; results(); end
   endtask
   function automatic logic [63:0] swap(input logic [63:0] d);
      for (int i = 0; i < 8; i++) swap[8*i +: 8] = d[56-8*i +: 8];
   endfunction
   // ==========================================
   // Sequence
   initial begin
      repeat (6) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      @(negedge i_clk);
      chk(o_map, 64'h0);
      chk({60'h0, o_sub0_prot, o_buf1_clobbered, lnk.so_oe}, 64'h0);
      @(posedge i_clk);
      i_wp_n <= 1'b0;
      cmd(2'h0, 64'h0);
      busy_len(nb);
      chk(64'(nb) | o_map, 64'h0);
      @(posedge i_clk);
      i_wp_n <= 1'b1;
      cmd(2'h0, 64'h0);
      busy_len(nb);
      chk(64'(nb >= spm_pkg::ERASE_CYC - 4 && nb <= spm_pkg::ERASE_CYC + 4),
          64'h1);
      chk(o_map, ALL_FF);
      // Program issued while busy must not land
      @(posedge i_clk);
      i_prot_en <= 1'b1;
      i_array_wr_req <= 1'b1;
      cmd(2'h0, 64'h0);
      repeat (10) @(negedge i_clk);
      chk({63'h0, o_busy}, 64'h1);
      cmd(2'h1, 64'h0);
      busy_len(nb);
      chk(o_map, ALL_FF);
      chk({61'h0, o_sub0_prot, o_array_wr_refused}, 64'h7);
      cmd(2'h2, 64'h0);
      chk(o_rdata, ALL_FF);
      cmd(2'h1, WD);
      busy_len(nb);
      chk(64'(nb >= spm_pkg::PROG_CYC - 4 && nb <= spm_pkg::PROG_CYC + 4),
          64'h1);
      chk(o_map, swap(WD));
      chk({61'h0, o_buf1_clobbered, o_sub0_prot}, 64'h6);
      chk({63'h0, o_array_wr_refused}, 64'h0);
      cmd(2'h2, 64'h0);
      chk(o_rdata, WD);
      repeat (10) @(negedge i_clk);
      chk({63'h0, lnk.so_oe}, 64'h0);
      @(posedge i_clk);
      i_wp_n <= 1'b0;
      cmd(2'h0, 64'h0);
      busy_len(nb);
      chk(64'(nb), 64'h0);
      chk(o_map, swap(WD));
      chk(64'(n_mod <= spm_pkg::CYCLE_LIMIT), 64'h1);
      results();
   end
endmodule // testbench
`default_nettype wire
